// ==== lcc_cfg.svh ====
// Timing counts, line numbers and output levels for the line-21 caption inserter
`ifndef LCC_CFG_SVH
`define LCC_CFG_SVH
`define LCC_CLK_PERIOD_NS 100
`define LCC_BIT_PERIOD_NS 1987
`define LCC_BIT_CLKS (`LCC_BIT_PERIOD_NS / `LCC_CLK_PERIOD_NS)
`define LCC_START_DELAY_NS 10500
`define LCC_START_CLKS ((`LCC_START_DELAY_NS + `LCC_CLK_PERIOD_NS - 1) / `LCC_CLK_PERIOD_NS)
`define LCC_RUNIN_CYCLES 7
`define LCC_HOLD_BITS 2
`define LCC_PAYLOAD_BITS 16
`define LCC_LINE_ODD_CAPTION 10'h015
`define LCC_LINE_EVEN_CAPTION 10'h11c
`define LCC_LINE_EVEN_IGNORE 10'h11a
`define LCC_BLANK_LEVEL 8'h10
`define LCC_HIGH_LEVEL 8'h50
`define LCC_FSEL_ODD_BIT 0
`define LCC_FSEL_EVEN_BIT 1
`endif

// ==== lcc_pkg.sv ====
// Types shared by the caption inserter files
package lcc_pkg;
   typedef enum logic [2:0] {
      LCC_IDLE  = 3'b000,
      LCC_WAIT  = 3'b001,
      LCC_RUNIN = 3'b011,
      LCC_HOLD  = 3'b010,
      LCC_START = 3'b110,
      LCC_DATA  = 3'b111,
      LCC_DONE  = 3'b101
   } lcc_state_t;
endpackage

// ==== lcc_runin_wave.sv ====
// Run-in sinusoid lookup: one full cycle over sixteen phase steps
`timescale 1ns/1ps
`include "lcc_cfg.svh"
module lcc_runin_wave (
   input wire logic [3:0] i_phase,
   output logic [7:0] o_level
);
   logic [7:0] swing;

   // Raised cosine so each cycle starts and ends at blanking level
   always_comb begin
      unique case (i_phase)
         4'h0: swing = 8'h00;
         4'h1: swing = 8'h02;
         4'h2: swing = 8'h09;
         4'h3: swing = 8'h14;
         4'h4: swing = 8'h20;
         4'h5: swing = 8'h2c;
         4'h6: swing = 8'h37;
         4'h7: swing = 8'h3e;
         4'h8: swing = 8'h40;
         4'h9: swing = 8'h3e;
         4'ha: swing = 8'h37;
         4'hb: swing = 8'h2c;
         4'hc: swing = 8'h20;
         4'hd: swing = 8'h14;
         4'he: swing = 8'h09;
         4'hf: swing = 8'h02;
      endcase
      o_level = `LCC_BLANK_LEVEL + swing;
   end
endmodule

// ==== lcc_inserter.sv ====
// Line-21 closed-caption inserter for the encoder video path
`timescale 1ns/1ps
`include "lcc_cfg.svh"
module lcc_inserter #(
   parameter int BIT_CLKS = `LCC_BIT_CLKS,
   parameter int START_CLKS = `LCC_START_CLKS
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_line_start,
   input wire logic [9:0] i_line_number,
   input wire logic i_field_odd,
   input wire logic [7:0] i_pixel,
   input wire logic [1:0] i_caption_field_select,
   input wire logic i_caption_load,
   input wire logic [15:0] i_caption_payload_bytes,
   input wire logic i_ext_caption_load,
   input wire logic [15:0] i_extended_caption_payload_bytes,
   output logic [7:0] o_video,
   output logic o_caption_active,
   output logic o_pixel_ignored
);
   // Twelve bits hold the start delay count with room for faster pixel clocks
   localparam int CNT_W = 12;
   localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CLKS - 1);
   localparam logic [CNT_W-1:0] START_LAST = CNT_W'(START_CLKS - 1);
   localparam logic [4:0] RUNIN_LAST = 5'(`LCC_RUNIN_CYCLES - 1);
   localparam logic [4:0] HOLD_LAST = 5'(`LCC_HOLD_BITS - 1);
   localparam logic [4:0] DATA_LAST = 5'(`LCC_PAYLOAD_BITS - 1);

   lcc_pkg::lcc_state_t state_q;
   lcc_pkg::lcc_state_t state_d;
   logic [15:0] cc_bytes_q;
   logic [15:0] ext_bytes_q;
   logic [15:0] shift_q;
   logic [CNT_W-1:0] clk_cnt_q;
   logic [4:0] bit_cnt_q;
   logic [7:0] video_q;
   logic active_q;
   logic ignored_q;
   logic odd_line;
   logic even_line;
   logic ignore_line;
   logic bit_end;
   logic [3:0] phase;
   logic [CNT_W+3:0] phase_wide;
   logic [7:0] runin_level;
   logic [7:0] wave_level;

   // Byte registers loaded as a pair; bit 7:0 is the low byte
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         cc_bytes_q <= 16'h0000;
      end else if (i_caption_load) begin
         cc_bytes_q <= i_caption_payload_bytes;
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         ext_bytes_q <= 16'h0000;
      end else if (i_ext_caption_load) begin
         ext_bytes_q <= i_extended_caption_payload_bytes;
      end
   end

   // Line qualification from the encoder's own line and field counters
   assign odd_line = i_field_odd && (i_line_number == `LCC_LINE_ODD_CAPTION)
      && i_caption_field_select[`LCC_FSEL_ODD_BIT];
   assign even_line = !i_field_odd && (i_line_number == `LCC_LINE_EVEN_CAPTION)
      && i_caption_field_select[`LCC_FSEL_EVEN_BIT];
   // Line 282 carries no caption here, but its picture samples are still dropped
   assign ignore_line = (i_line_number == `LCC_LINE_ODD_CAPTION)
      || (i_line_number == `LCC_LINE_EVEN_IGNORE) || even_line;

   assign bit_end = (clk_cnt_q == BIT_LAST);

   // A line start mid-sequence is refused; only DONE hands back to IDLE
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         lcc_pkg::LCC_IDLE: begin
            if (i_line_start && (odd_line || even_line)) begin
               state_d = lcc_pkg::LCC_WAIT;
            end
         end
         lcc_pkg::LCC_WAIT: begin
            if (clk_cnt_q == START_LAST) begin
               state_d = lcc_pkg::LCC_RUNIN;
            end
         end
         lcc_pkg::LCC_RUNIN: begin
            if (bit_end && bit_cnt_q == RUNIN_LAST) begin
               state_d = lcc_pkg::LCC_HOLD;
            end
         end
         lcc_pkg::LCC_HOLD: begin
            if (bit_end && bit_cnt_q == HOLD_LAST) begin
               state_d = lcc_pkg::LCC_START;
            end
         end
         lcc_pkg::LCC_START: begin
            if (bit_end) begin
               state_d = lcc_pkg::LCC_DATA;
            end
         end
         lcc_pkg::LCC_DATA: begin
            if (bit_end && bit_cnt_q == DATA_LAST) begin
               state_d = lcc_pkg::LCC_DONE;
            end
         end
         lcc_pkg::LCC_DONE: begin
            if (i_line_start) begin
               state_d = lcc_pkg::LCC_IDLE;
            end
         end
         default: begin
            state_d = lcc_pkg::LCC_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         state_q <= lcc_pkg::LCC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Cycle counter restarts at each phase change so every bit has equal length
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         clk_cnt_q <= '0;
      end else if (state_d != state_q) begin
         clk_cnt_q <= '0;
      end else if (state_q == lcc_pkg::LCC_WAIT) begin
         clk_cnt_q <= clk_cnt_q + CNT_W'(1);
      end else if (bit_end) begin
         clk_cnt_q <= '0;
      end else begin
         clk_cnt_q <= clk_cnt_q + CNT_W'(1);
      end
   end

   // Counts bits within the current phase; cleared on every phase change
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         bit_cnt_q <= 5'h00;
      end else if (state_d != state_q) begin
         bit_cnt_q <= 5'h00;
      end else if (bit_end) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   // Payload is frozen at line start, so a load mid-line cannot tear a frame
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         shift_q <= 16'h0000;
      end else if (state_q == lcc_pkg::LCC_IDLE && i_line_start) begin
         shift_q <= odd_line ? cc_bytes_q : ext_bytes_q;
      end else if (state_q == lcc_pkg::LCC_DATA && bit_end) begin
         shift_q <= {1'b0, shift_q[15:1]};
      end
   end

   // Run-in phase follows the cycle counter, so it is locked to the data rate
   assign phase_wide = {clk_cnt_q, 4'h0} / (CNT_W + 4)'(BIT_CLKS);
   assign phase = phase_wide[3:0];

   lcc_runin_wave u_runin_wave (
      .i_phase(phase),
      .o_level(runin_level)
   );

   always_comb begin
      unique case (state_q)
         lcc_pkg::LCC_RUNIN: wave_level = runin_level;
         lcc_pkg::LCC_START: wave_level = `LCC_HIGH_LEVEL;
         lcc_pkg::LCC_DATA: wave_level = shift_q[0] ? `LCC_HIGH_LEVEL : `LCC_BLANK_LEVEL;
         default: wave_level = `LCC_BLANK_LEVEL;
      endcase
   end

   // Output mux; a caption line never passes picture samples through
   // Pixels share this flop so caption and picture leave with one latency
   always_ff @(posedge i_clock) begin
      if (!i_rst_b) begin
         video_q <= `LCC_BLANK_LEVEL;
         active_q <= 1'b0;
         ignored_q <= 1'b0;
      end else begin
         active_q <= (state_q != lcc_pkg::LCC_IDLE);
         ignored_q <= ignore_line || (state_q != lcc_pkg::LCC_IDLE);
         if (state_q != lcc_pkg::LCC_IDLE) begin
            video_q <= wave_level;
         end else if (ignore_line) begin
            video_q <= `LCC_BLANK_LEVEL;
         end else begin
            video_q <= i_pixel;
         end
      end
   end

   assign o_video = video_q;
   assign o_caption_active = active_q;
   assign o_pixel_ignored = ignored_q;
endmodule

// ==== lcc_chk.sv ====
// Port checks for the caption inserter
`timescale 1ns/1ps
module lcc_chk #(
   parameter int BIT_CLKS = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_line_start,
   input wire logic [9:0] i_line_number,
   input wire logic i_field_odd,
   input wire logic [7:0] i_pixel,
   input wire logic [1:0] i_caption_field_select,
   input wire logic [7:0] o_video,
   input wire logic o_caption_active,
   input wire logic o_pixel_ignored
);
   logic odd_go, even_go, kept;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   assign odd_go = i_line_number == 10'h015 && i_field_odd && i_caption_field_select[0];
   assign even_go = i_line_number == 10'h11c && !i_field_odd && i_caption_field_select[1];
   assign kept = i_line_number == 10'h015 || i_line_number == 10'h11a;
   odd_start_a: assert property (i_line_start && !o_caption_active && odd_go
      |-> ##[1:3] o_caption_active) else $error("odd caption missing");
   even_start_a: assert property (i_line_start && !o_caption_active && even_go
      |-> ##[1:3] o_caption_active) else $error("even caption missing");
   no_start_a: assert property (i_line_start && !o_caption_active && !(odd_go || even_go)
      |-> ##1 !o_caption_active [*3]) else $error("caption on wrong line");
   runin_soon_a: assert property ($rose(o_caption_active)
      |-> ##[1:8] (o_video != 8'h10 && o_video != 8'h50)) else $error("no run-in");
   start_bit_a: assert property ((o_video == 8'h10) [*7] ##1 (o_video == 8'h50)
      |=> (o_video == 8'h50) [*3]) else $error("short high bit");
   line_ignored_a: assert property (kept && $past(i_line_number, 2) == i_line_number
      |-> o_pixel_ignored) else $error("pixels not ignored");
   pixel_hidden_a: assert property (o_pixel_ignored [*3] |-> $past(o_video) != i_pixel)
      else $error("pixel leaked");
   busy_hold_a: assert property ($rose(o_caption_active) |-> o_caption_active [*8])
      else $error("caption cut short");
   cover property ($rose(o_caption_active) && even_go);
   cover property (o_pixel_ignored && i_line_number == 10'h11a);
   cover property (i_line_start && o_caption_active);
endmodule

// ==== lcc_dec_model.sv ====
// Receiver model: finds the start bit after the blank hold, samples bits mid-way
`timescale 1ns/1ps
module lcc_dec_model #(
   parameter int BIT_CLKS = 4
) (
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic [7:0] i_video,
   output logic [15:0] o_bytes,
   output logic o_done
);
   int blank_q, cnt_q;
   always_ff @(posedge i_clock) begin
      o_done <= 1'b0;
      blank_q <= (i_video == 8'h10) ? blank_q + 1 : 0;
      if (!i_rst_b) begin
         cnt_q <= -1;
      end else if (cnt_q < 0) begin
         // A long idle blank is no hold, so only a short run may precede the start
         if (i_video == 8'h50 && blank_q >= 2 * BIT_CLKS - 2
            && blank_q <= 2 * BIT_CLKS + 2) cnt_q <= 0;
      end else begin
         cnt_q <= cnt_q + 1;
         if (cnt_q + 1 >= BIT_CLKS && (cnt_q + 1) % BIT_CLKS == BIT_CLKS / 2) begin
            o_bytes <= {i_video == 8'h50, o_bytes[15:1]};
            if ((cnt_q + 1) / BIT_CLKS == 16) begin
               o_done <= 1'b1;
               cnt_q <= -1;
            end
         end
      end
   end
endmodule

// ==== line21_caption_inserter_bench.sv ====
// Bench: line timing into the inserter, caption decoded by the receiver model
`timescale 1ns/1ps
module line21_caption_inserter_bench;
   logic i_clock = 1'b0, i_rst_b = 1'b0, i_line_start = 1'b0, i_field_odd = 1'b0, ld = 1'b0;
   logic [9:0] i_line_number = 10'h000;
   logic [1:0] i_caption_field_select = 2'b00;
   logic [15:0] cb = 16'h0000, eb = 16'h0000, dbytes;
   logic [7:0] o_video;
   logic o_caption_active, o_pixel_ignored, ddone;
   int n_mismatch = 0, checks_done = 0, cycles = 0;
   always #50 i_clock = ~i_clock; // One steady pixel clock, no divided phase to order
   lcc_inserter #(.BIT_CLKS(4), .START_CLKS(3)) uut (.i_clock, .i_rst_b, .i_line_start,
      .i_line_number, .i_field_odd, .i_pixel(8'hab), .i_caption_field_select,
      .i_caption_load(ld), .i_caption_payload_bytes(cb), .i_ext_caption_load(ld),
      .i_extended_caption_payload_bytes(eb), .o_video, .o_caption_active, .o_pixel_ignored);
   lcc_dec_model #(.BIT_CLKS(4)) u_dec (.i_clock, .i_rst_b, .i_video(o_video),
      .o_bytes(dbytes), .o_done(ddone));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // The following line start is what closes a running caption
   task automatic run_line(input logic [9:0] l, input logic f, output logic got,
      output logic [15:0] d, output logic ig, output int n_hi);
      got = 1'b0;
      d = 16'h0000;
      n_hi = 0;
      i_line_number = l;
      i_field_odd = f;
      i_line_start = 1'b1;
      repeat (150) begin
         @(posedge i_clock) #1 i_line_start = 1'b0;
         if (ddone === 1'b1) got = 1'b1;
         if (ddone === 1'b1) d = dbytes;
         if (o_video === 8'h50) n_hi++;
      end
      ig = o_pixel_ignored;
      i_line_number = l + 10'h001;
      i_line_start = 1'b1;
      @(posedge i_clock) #1 i_line_start = 1'b0;
      repeat (10) @(posedge i_clock);
      #1 check("idle after line", o_caption_active, 16'h0000);
      check("pixel through", {8'h00, o_video}, 16'h00ab);
   endtask
   task automatic t_reset;
      repeat (8) @(posedge i_clock);
      #1 check("reset video", o_video, 16'h0010);
      i_rst_b = 1'b1;
      $display("t_reset done");
   endtask
   task automatic t_lines;
      logic got, ig;
      logic [15:0] d;
      logic [4:0] want;
      int n_hi;
      logic [9:0] lnum [5] = '{10'h015, 10'h11c, 10'h015, 10'h11a, 10'h11c};
      for (int s = 0; s < 4; s++) begin
         i_caption_field_select = s[1:0];
         want = {3'b000, s[1:0]};
         cb = 16'h3ca5 ^ {4{s[3:0]}};
         eb = 16'h5a0f ^ {4{s[3:0]}};
         ld = 1'b1;
         @(posedge i_clock) #1 ld = 1'b0;
         for (int k = 0; k < 5; k++) begin
            run_line(lnum[k], k == 0 || k == 4, got, d, ig, n_hi);
            // Seven run-in peaks, a four-clock start bit, four clocks per payload one
            check("high samples", 16'(n_hi),
               want[k] ? 16'(11 + 4 * $countones(k == 0 ? cb : eb)) : 16'h0000);
            check("caption seen", got, want[k]);
            if (want[k]) check("bytes", d, k == 0 ? cb : eb);
            if (k < 4) check("ignored", ig, k == 1 ? s[1] : 1'b1);
         end
      end
      $display("t_lines done");
   endtask
   initial begin
      t_reset();
      t_lines();
      end_of_test();
   end
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 8000) begin
         n_mismatch++;
         end_of_test();
      end
   end
endmodule
bind lcc_inserter lcc_chk #(.BIT_CLKS(BIT_CLKS)) u_chk (.i_clock, .i_rst_b, .i_line_start,
   .i_line_number, .i_field_odd, .i_pixel, .i_caption_field_select, .o_video,
   .o_caption_active, .o_pixel_ignored);
